// [rtl/eight_sixteen_bit_timer_counter.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: 8/16-bit timer/counter with 8-bit prescaler and overflow interrupt
// Assumes: i_sys_clk is the instruction-cycle clock; i_count_pin is asynchronous
// Notes:   16-bit value is read and written atomically through a high-byte latch
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module eight_sixteen_bit_timer_counter
(
	input  wire logic              i_sys_clk,
	input  wire logic              i_rst_n,
	input  wire tmr_pkg::bus_req_s i_bus,
	input  wire logic              i_count_pin,
	input  wire logic              i_sleep,
	output logic [7:0]             o_rdata,
	output logic                   o_irq
);
	import tmr_pkg::*;

	tmr_state_s st_ff;
	tmr_state_s nxt_st;

	////////////////////////////////////////////////////////////////////////
	// Decoded control fields
	logic       run;
	logic       narrow;
	logic       ext_src;
	logic       fall_edge;
	logic       bypass;
	logic [2:0] ratio;
	logic [7:0] div_mask;

	assign run       = st_ff.ctrl[BIT_COUNTER_RUN];
	assign narrow    = st_ff.ctrl[BIT_NARROW_WIDTH];
	assign ext_src   = st_ff.ctrl[BIT_SOURCE_SELECT];
	assign fall_edge = st_ff.ctrl[BIT_PIN_EDGE_SELECT];
	assign bypass    = st_ff.ctrl[BIT_DIVIDER_BYPASS];
	assign ratio     = st_ff.ctrl[RATIO_MSB:RATIO_LSB];

	// Low bits that must all be ones to finish one prescale period
	assign div_mask  = 8'((16'h0002 << ratio) - 16'h0001);

	////////////////////////////////////////////////////////////////////////
	// Register port decode
	logic wr_ctrl;
	logic wr_low;
	logic wr_high;
	logic wr_clr;
	logic wr_en;
	logic rd_low;

	assign wr_ctrl = i_bus.wr && (i_bus.addr == OFS_COUNTER_CONTROL);
	assign wr_low  = i_bus.wr && (i_bus.addr == OFS_COUNT_LOW_BYTE);
	assign wr_high = i_bus.wr && (i_bus.addr == OFS_COUNT_HIGH_LATCH);
	assign wr_clr  = i_bus.wr && (i_bus.addr == OFS_IRQ_CLEAR);
	assign wr_en   = i_bus.wr && (i_bus.addr == OFS_IRQ_CONTROL);
	assign rd_low  = i_bus.rd && (i_bus.addr == OFS_COUNT_LOW_BYTE);

	////////////////////////////////////////////////////////////////////////
	// Count event path: pin edge or cycle, gating, prescaler
	logic pin_agree;
	logic pin_edge;
	logic src_ev;
	logic gated_ev;
	logic pre_done;
	logic cnt_pulse;
	logic cnt_step;
	logic wrap_low;
	logic wrap_wide;

	// A pin change counts once the second and third stages agree
	assign pin_agree = (st_ff.sync[1] == st_ff.sync[2]);
	assign pin_edge  = pin_agree && (st_ff.sync[2] != st_ff.lvl)
		&& (st_ff.sync[2] == !fall_edge);
	assign src_ev    = ext_src ? pin_edge : 1'b1;
	assign gated_ev  = src_ev && run && !i_sleep;
	assign pre_done  = ((st_ff.pre & div_mask) == div_mask);
	// Bypass is read live, so the assignment may change at any time
	assign cnt_pulse = bypass ? gated_ev : (gated_ev && pre_done);
	assign cnt_step  = cnt_pulse && (st_ff.inh == 2'h0) && !wr_low;
	assign wrap_low  = cnt_step && (st_ff.cnt[7:0] == LOW_MAX);
	assign wrap_wide = cnt_step && (st_ff.cnt == WIDE_MAX);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		nxt_st = st_ff;

		// Three-stage synchronizer and filtered pin level
		nxt_st.sync = {st_ff.sync[1:0], i_count_pin};
		if (pin_agree)
		begin
			nxt_st.lvl = st_ff.sync[2];
		end

		// Control register
		if (wr_ctrl)
		begin
			nxt_st.ctrl = i_bus.wdata;
		end

		// Prescaler: hidden 8-bit counter, cleared by any count write
		if (wr_low)
		begin
			nxt_st.pre = 8'h00;
		end
		else if (gated_ev && !bypass)
		begin
			nxt_st.pre = pre_done ? 8'h00 : st_ff.pre + 8'h01;
		end

		// Increment inhibit after a count write
		if (wr_low)
		begin
			nxt_st.inh = WRITE_INHIBIT_CYCLES;
		end
		else if (st_ff.inh != 2'h0)
		begin
			nxt_st.inh = st_ff.inh - 2'h1;
		end

		// Counter value: write, or one step
		if (wr_low)
		begin
			nxt_st.cnt[7:0] = i_bus.wdata;
			if (!narrow)
			begin
				nxt_st.cnt[15:8] = st_ff.latch;
			end
		end
		else if (cnt_step)
		begin
			if (narrow)
			begin
				nxt_st.cnt[7:0] = st_ff.cnt[7:0] + 8'h01;
			end
			else
			begin
				nxt_st.cnt = st_ff.cnt + 16'h0001;
			end
		end

		// High-byte latch: written directly, or captured on a low read in 16-bit mode
		if (wr_high)
		begin
			nxt_st.latch = i_bus.wdata;
		end
		else if (rd_low && !narrow)
		begin
			nxt_st.latch = st_ff.cnt[15:8];
		end

		// Overflow flag: a set in the same cycle wins over a clear
		if (wr_clr && i_bus.wdata[BIT_OVERFLOW])
		begin
			nxt_st.flag = 1'b0;
		end
		if (narrow ? wrap_low : wrap_wide)
		begin
			nxt_st.flag = 1'b1;
		end
		if (wr_en)
		begin
			nxt_st.irq_en = i_bus.wdata[BIT_OVERFLOW];
		end
		nxt_st.irq = nxt_st.flag && nxt_st.irq_en;

		// Read data, valid in the cycle after the strobe only
		nxt_st.rdata = 8'h00;
		if (i_bus.rd)
		begin
			case (i_bus.addr)
				OFS_COUNTER_CONTROL:  nxt_st.rdata = st_ff.ctrl;
				OFS_COUNT_LOW_BYTE:   nxt_st.rdata = st_ff.cnt[7:0];
				OFS_COUNT_HIGH_LATCH: nxt_st.rdata = st_ff.latch;
				OFS_IRQ_STATUS:       nxt_st.rdata = {7'h00, st_ff.flag};
				OFS_IRQ_CONTROL:      nxt_st.rdata = {7'h00, st_ff.irq_en};
				default:              nxt_st.rdata = 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			st_ff <= STATE_RESET;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign o_rdata = st_ff.rdata;
	assign o_irq   = st_ff.irq;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_low_write;
		wr_low;
	endsequence

	sequence s_quiet_two;
		!wr_low [*2];
	endsequence

	a_run_halt: assert property (!run && !wr_low |=> $stable(st_ff.cnt))
		else $error("count moved while halted");

	a_narrow_high: assert property (narrow && $past(narrow) |-> $stable(st_ff.cnt[15:8]))
		else $error("high byte moved in 8-bit mode");

	a_timer_tick: assert property (run && !ext_src && bypass && !narrow && !i_sleep && !wr_low
		&& st_ff.inh == 2'h0 |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
		else $error("timer did not step once per cycle");

	a_write_inhibit: assert property (s_low_write ##1 s_quiet_two |=> $stable(st_ff.cnt))
		else $error("count stepped inside inhibit window");

	a_pre_clear: assert property (s_low_write |=> st_ff.pre == 8'h00 && $stable(st_ff.ctrl))
		else $error("prescaler not cleared by count write");

	a_wrap_flag: assert property (!narrow && cnt_step && st_ff.cnt == WIDE_MAX
		|=> st_ff.flag && st_ff.cnt == 16'h0000)
		else $error("16-bit wrap did not set flag");

	a_irq_mask: assert property (o_irq == (st_ff.flag && st_ff.irq_en))
		else $error("interrupt output not gated by enable");

	a_sleep_stop: assert property (i_sleep && !wr_low |=> $stable(st_ff.cnt))
		else $error("count moved during sleep");

	a_latch_copy: assert property (rd_low && !narrow && !wr_high
		|=> st_ff.latch == $past(st_ff.cnt[15:8]))
		else $error("low read did not capture high byte");

	a_wide_load: assert property (wr_low && !narrow
		|=> st_ff.cnt == {$past(st_ff.latch), $past(i_bus.wdata)})
		else $error("16-bit write not atomic");

	////////////////////////////////////////////////////////////////////////
	// Further checks on the event path, prescaler, flag and latch

	// One accepted pin edge that is allowed to move the count
	sequence s_pin_step;
		ext_src && bypass && run && !i_sleep && pin_edge && (st_ff.inh == 2'h0) && !wr_low;
	endsequence

	// One prescaler event that does not finish the period
	sequence s_pre_tick;
		!bypass && gated_ev && !pre_done && !wr_low;
	endsequence

	// One prescaler event that finishes the period
	sequence s_pre_end;
		!bypass && gated_ev && pre_done && !wr_low;
	endsequence

	// Control bits come back as all ones after reset
	a_reset_state: assert property (@(posedge i_sys_clk) disable iff (1'b0)
		!i_rst_n |=> st_ff.ctrl == CTRL_RESET && st_ff.latch == LATCH_RESET && !o_irq)
		else $error("reset state wrong");

	// An 8-bit wrap sets the flag and clears the low byte
	a_narrow_wrap: assert property (narrow && cnt_step && st_ff.cnt[7:0] == LOW_MAX
		|=> st_ff.flag && st_ff.cnt[7:0] == 8'h00)
		else $error("8-bit wrap did not set flag");

	// A wrap always leaves the flag set, even beside a clear
	a_set_wins: assert property ((narrow ? wrap_low : wrap_wide) |=> st_ff.flag)
		else $error("wrap lost against clear");

	// The flag holds until software clears it
	a_flag_sticky: assert property (st_ff.flag && !(wr_clr && i_bus.wdata[BIT_OVERFLOW])
		|=> st_ff.flag)
		else $error("flag dropped without clear");

	// A clear with no wrap beside it drops the flag
	a_flag_clear: assert property (wr_clr && i_bus.wdata[BIT_OVERFLOW]
		&& !(narrow ? wrap_low : wrap_wide) |=> !st_ff.flag)
		else $error("flag not cleared");

	// Bypassed prescaler stands still
	a_pre_hold: assert property (bypass && !wr_low |=> $stable(st_ff.pre))
		else $error("prescaler moved while bypassed");

	// Prescaler counts one per event inside a period
	a_pre_step: assert property (s_pre_tick |=> st_ff.pre == $past(st_ff.pre) + 8'h01)
		else $error("prescaler did not advance");

	// Prescaler restarts once a period is complete
	a_pre_wrap: assert property (s_pre_end |=> st_ff.pre == 8'h00)
		else $error("prescaler did not restart");

	// Prescaler holds while the counter is halted
	a_halt_pre: assert property (!run && !wr_low |=> $stable(st_ff.pre))
		else $error("prescaler moved while halted");

	// Prescaler holds while asleep
	a_sleep_pre: assert property (i_sleep && !wr_low |=> $stable(st_ff.pre))
		else $error("prescaler moved during sleep");

	// An accepted pin edge moves the low byte by one
	a_pin_count: assert property (s_pin_step
		|=> st_ff.cnt[7:0] == $past(st_ff.cnt[7:0]) + 8'h01)
		else $error("pin edge not counted");

	// The filtered level only follows agreeing stages
	a_pin_filter: assert property (!pin_agree |=> $stable(st_ff.lvl))
		else $error("pin level took an unsettled value");

	// Only the selected edge direction is accepted
	a_edge_dir: assert property (pin_edge |-> st_ff.sync[2] != fall_edge)
		else $error("wrong pin edge accepted");

	// A count write starts the inhibit window
	a_inh_load: assert property (wr_low |=> st_ff.inh == WRITE_INHIBIT_CYCLES)
		else $error("inhibit window not started");

	// The inhibit window counts down once per cycle
	a_inh_fall: assert property (st_ff.inh != 2'h0 && !wr_low
		|=> st_ff.inh == $past(st_ff.inh) - 2'h1)
		else $error("inhibit window not counting down");

	// Control writes take effect at once, even while running
	a_ctrl_write: assert property (wr_ctrl |=> st_ff.ctrl == $past(i_bus.wdata))
		else $error("control write lost");

	// Latch writes land in the latch
	a_latch_write: assert property (wr_high |=> st_ff.latch == $past(i_bus.wdata))
		else $error("latch write lost");

	// In 8-bit mode a low read leaves the latch alone
	a_narrow_latch: assert property (rd_low && narrow && !wr_high |=> $stable(st_ff.latch))
		else $error("latch copied in 8-bit mode");

	// In 8-bit mode a count write leaves the high byte alone
	a_narrow_load: assert property (wr_low && narrow
		|=> st_ff.cnt[15:8] == $past(st_ff.cnt[15:8]))
		else $error("high byte loaded in 8-bit mode");

	// Reading the latch returns the latch, never the live high byte
	a_latch_read: assert property (i_bus.rd && i_bus.addr == OFS_COUNT_HIGH_LATCH
		|=> o_rdata == $past(st_ff.latch))
		else $error("latch read returned wrong byte");

endmodule // eight_sixteen_bit_timer_counter

// [common/tmr_pkg.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the 8/16-bit timer/counter
// Assumes: 8-bit register port, one instruction cycle per system clock
// Notes:   Register offsets are word indices on the plain register port
//////////////////////////////////////////////////////////////////////////////
package tmr_pkg;

	// Register port widths
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;

	// Register offsets
	localparam logic [2:0] OFS_COUNTER_CONTROL  = 3'h0;
	localparam logic [2:0] OFS_COUNT_LOW_BYTE   = 3'h1;
	localparam logic [2:0] OFS_COUNT_HIGH_LATCH = 3'h2;
	localparam logic [2:0] OFS_IRQ_STATUS       = 3'h3;
	localparam logic [2:0] OFS_IRQ_CLEAR        = 3'h4;
	localparam logic [2:0] OFS_IRQ_CONTROL      = 3'h5;

	// Field positions in counter_control
	localparam int unsigned BIT_COUNTER_RUN     = 7;
	localparam int unsigned BIT_NARROW_WIDTH    = 6;
	localparam int unsigned BIT_SOURCE_SELECT   = 5;
	localparam int unsigned BIT_PIN_EDGE_SELECT = 4;
	localparam int unsigned BIT_DIVIDER_BYPASS  = 3;
	localparam int unsigned RATIO_MSB           = 2;
	localparam int unsigned RATIO_LSB           = 0;

	// Field positions in the interrupt registers
	localparam int unsigned BIT_OVERFLOW = 0;

	// Reset values
	localparam logic [7:0]  CTRL_RESET  = 8'hff;
	localparam logic [7:0]  LATCH_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;

	// Timing counts, in instruction cycles
	localparam logic [1:0]  WRITE_INHIBIT_CYCLES = 2'h2;

	// Counter limits
	localparam logic [7:0]  LOW_MAX  = 8'hff;
	localparam logic [15:0] WIDE_MAX = 16'hffff;

	// One register port request
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_s;

	// Whole state of the timer block
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [15:0] cnt;
		logic [7:0]  latch;
		logic [7:0]  pre;
		logic [1:0]  inh;
		logic [2:0]  sync;
		logic        lvl;
		logic        flag;
		logic        irq_en;
		logic        irq;
		logic [7:0]  rdata;
	} tmr_state_s;

	localparam tmr_state_s STATE_RESET = '{
		ctrl:   CTRL_RESET,
		cnt:    COUNT_RESET,
		latch:  LATCH_RESET,
		pre:    8'h00,
		inh:    2'h0,
		sync:   3'h0,
		lvl:    1'b0,
		flag:   1'b0,
		irq_en: 1'b0,
		irq:    1'b0,
		rdata:  8'h00
	};

endpackage

// [sim/count_source_model.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: External clock source driving the count pin
// Assumes: Edges are far slower than the system clock
// Notes:   Edges land off the system clock grid
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module count_source_model
#(
	parameter int HALF_NS = 437
)
(
	output logic o_pin
);
	// Pin starts low and keeps the level of its last toggle between bursts
	initial o_pin = 1'b0;

	// Toggle the pin n times, each level held several cycles for the synchronizer
	task automatic toggle(input int n);
		repeat (n)
		begin
			#(HALF_NS);
			o_pin = ~o_pin;
		end
	endtask
endmodule // count_source_model

// [sim/eight_sixteen_bit_timer_counter_tb_top.sv]
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the 8/16-bit timer/counter
// Assumes: Read data stand only in the cycle after the read strobe
// Notes:   Bus tasks are entered just after a rising edge, except idle after the pin toggles in t_pin
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module eight_sixteen_bit_timer_counter_tb_top;
	import tmr_pkg::*;
	logic       sys_clk;
	logic       rst_n;
	bus_req_s   bus;
	logic       sleep;
	logic       pin;
	logic [7:0] rdata;
	logic       irq;
	int         bad_count;
	int         cmp_count;

	// Clock at 10 MHz
	initial sys_clk = 1'b0;
	always #50 sys_clk = ~sys_clk;

	eight_sixteen_bit_timer_counter u_dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_bus(bus),
		.i_count_pin(pin), .i_sleep(sleep), .o_rdata(rdata), .o_irq(irq));
	count_source_model #(.HALF_NS(437)) u_src (.o_pin(pin));

	// Count and report one comparison
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus cycles
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		bus <= '0;
		@(negedge sys_clk);
		chk(rdata, exp);
		@(posedge sys_clk);
	endtask
	task automatic idle(input int n);
		bus <= '0;
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic irqchk(input logic exp);
		@(negedge sys_clk);
		chk({7'h00, irq}, {7'h00, exp});
		@(posedge sys_clk);
	endtask

	// Reset values and an unmapped offset
	task automatic t_reset;
		rd(OFS_COUNTER_CONTROL, 8'hff);
		rd(OFS_COUNT_HIGH_LATCH, 8'h00);
		rd(OFS_IRQ_STATUS, 8'h00);
		rd(3'h6, 8'h00);
		$display("reset test done");
	endtask

	// Timer mode, write inhibit, wrap, halt and interrupt
	task automatic t_timer;
		wr(OFS_COUNTER_CONTROL, 8'hc8);
		wr(OFS_COUNT_LOW_BYTE, 8'hfd);
		rd(OFS_COUNT_LOW_BYTE, 8'hfd);
		rd(OFS_COUNT_LOW_BYTE, 8'hfd);
		rd(OFS_COUNT_LOW_BYTE, 8'hff);
		wr(OFS_COUNTER_CONTROL, 8'h48);
		rd(OFS_COUNT_LOW_BYTE, 8'h02);
		rd(OFS_IRQ_STATUS, 8'h01);
		irqchk(1'b0);
		wr(OFS_IRQ_CONTROL, 8'h01);
		idle(2);
		irqchk(1'b1);
		wr(OFS_IRQ_CLEAR, 8'h01);
		idle(2);
		irqchk(1'b0);
		rd(OFS_IRQ_STATUS, 8'h00);
		$display("timer test done");
	endtask

	// Sleep freezes the count
	task automatic t_sleep;
		sleep <= 1'b1;
		wr(OFS_COUNT_LOW_BYTE, 8'h10);
		wr(OFS_COUNTER_CONTROL, 8'hc8);
		idle(20);
		rd(OFS_COUNT_LOW_BYTE, 8'h10);
		sleep <= 1'b0;
		wr(OFS_COUNTER_CONTROL, 8'h08);
		$display("sleep test done");
	endtask

	// 16-bit mode through the high-byte latch
	task automatic t_wide;
		wr(OFS_COUNT_HIGH_LATCH, 8'h12);
		wr(OFS_COUNT_LOW_BYTE, 8'h34);
		wr(OFS_COUNT_HIGH_LATCH, 8'h00);
		rd(OFS_COUNT_LOW_BYTE, 8'h34);
		rd(OFS_COUNT_HIGH_LATCH, 8'h12);
		for (int k = 0; k < 2; k++)
		begin
			wr(OFS_COUNT_HIGH_LATCH, k ? 8'hff : 8'h12);
			wr(OFS_COUNT_LOW_BYTE, k ? 8'hfe : 8'hff);
			wr(OFS_COUNTER_CONTROL, 8'h88);
			idle(6);
			wr(OFS_COUNTER_CONTROL, 8'h08);
			rd(OFS_IRQ_STATUS, {7'h00, k[0]});
			rd(OFS_COUNT_LOW_BYTE, k ? 8'h04 : 8'h05);
			rd(OFS_COUNT_HIGH_LATCH, k ? 8'h00 : 8'h13);
		end
		wr(OFS_IRQ_CLEAR, 8'h01);
		$display("wide test done");
	endtask

	// Every prescale ratio, largest first so leftovers would show
	task automatic t_prescale;
		for (int r = 7; r >= 0; r--)
		begin
			wr(OFS_COUNT_LOW_BYTE, 8'h00);
			wr(OFS_COUNTER_CONTROL, {5'b10000, r[2:0]});
			idle((3 << r) - 1);
			wr(OFS_COUNTER_CONTROL, {5'b00000, r[2:0]});
			rd(OFS_COUNT_LOW_BYTE, 8'h01);
		end
		$display("prescale test done");
	endtask

	// Pin counting on each edge; five toggles give 3 chosen edges, 2 others
	task automatic t_pin;
		for (int e = 0; e < 2; e++)
		begin
			wr(OFS_COUNTER_CONTROL, {3'b111, e[0], 4'b1000});
			wr(OFS_COUNT_LOW_BYTE, 8'h00);
			idle(3);
			u_src.toggle(5);
			idle(10);
			rd(OFS_COUNT_LOW_BYTE, 8'h03);
		end
		$display("pin test done");
	endtask

	// Verdict
	task automatic results;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Hang guard
	initial
	begin
		#2000000;
		bad_count++;
		$display("[ERR] %0t run limit reached", $time);
		results();
	end

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		bus = '0;
		sleep = 1'b0;
		bad_count = 0;
		cmp_count = 0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset();
		t_timer();
		t_sleep();
		t_wide();
		t_prescale();
		t_pin();
		results();
	end
endmodule // eight_sixteen_bit_timer_counter_tb_top
